// File: logic/mdma_top.sv
// Data-move access unit: pointer registers, map control, stretch, on-chip SRAM and external bus.
// Assumes a core on the same clock driving the register port and move requests.
// Operation
// R1 - Enabled map: low 1kB served internally
// R2 - Enabled map: higher addresses go external
// R3 - Disabled map sends everything external
// R4 - Map bits from power register, live
// R5 - Full map: lock status byte at top
// R6 - Full map: reserved area, no bus
// R7 - Map changes never touch SRAM contents
// R8 - Internal moves take two machine cycles
// R9 - External move lasts stretch plus two
// R10 - Stretch resets to one
// R11 - Strobe width follows stretch setting
// R12 - Nonzero stretch adds setup and hold
// R13 - Stretch affects data moves only
// R14 - Two pointers at fixed offsets
// R15 - Select register: lsb only, rest zero
// R16 - Pointer operations use selected pointer
// R17 - Ports carry bus during external moves
// R18 - Machine cycle is four clocks
// R19 - Upper-only map code means disabled
// R20 - Reserved reads zero, writes dropped
`include "mdma_consts.svh"
`default_nettype none

module mdma_top #(
    parameter int SRAM_DEPTH = 1024
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    output logic      [7:0]  o_sfr_rdata,
    input  wire logic        i_ptr_inc,
    input  wire logic        i_ptr_load,
    input  wire logic [15:0] i_ptr_load_val,
    output logic      [15:0] o_ptr_active,
    input  wire logic        i_mv_req,
    input  wire logic        i_mv_we,
    input  wire logic        i_mv_use_ptr,
    input  wire logic [15:0] i_mv_addr,
    input  wire logic [7:0]  i_mv_wdata,
    output logic             o_mv_ready,
    output logic             o_mv_done,
    output logic      [7:0]  o_mv_rdata,
    input  wire logic [2:0]  i_lock_bits,
    input  wire logic [7:0]  i_p0_in,
    output logic      [7:0]  o_p0_out,
    output logic             o_p0_oe,
    output logic      [7:0]  o_p2_out,
    output logic             o_bus_active,
    output logic             o_ale,
    output logic             o_rd_n,
    output logic             o_wr_n
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]  ptr0_lo_q, ptr0_hi_q, ptr1_lo_q, ptr1_hi_q;
    logic        ptr_sel_q;
    logic [7:0]  stretch_ctl_q;
    logic [7:0]  pwr_mgmt_q;
    logic [15:0] ptr_sel_val;
    logic [15:0] mv_addr;
    logic        accept;
    mdma_pkg::mdma_state_t st_q;
    mdma_pkg::mdma_route_t acc_route;
    logic [5:0]  cnt_q;
    logic [5:0]  last_cnt;
    logic [15:0] addr_q;
    logic        we_q;
    logic [7:0]  wdata_q;
    logic [2:0]  stretch_q;
    logic        lock_q;
    logic [5:0]  ext_total;
    logic [5:0]  strobe_w;
    logic [5:0]  strobe_start;
    logic        strobe_on;
    logic        ale_on;
    logic [7:0]  p0_sync1_q, p0_sync2_q;
    logic [2:0]  lock_sync1_q, lock_sync2_q;
    logic        sram_en;
    logic [7:0]  sram_rdata;
    logic [7:0]  mv_rdata_q;

    // Route decode, shared by the sequencer and its checks
    function automatic mdma_pkg::mdma_route_t route_of(input logic [1:0] sel, input logic [15:0] a);
        mdma_pkg::mdma_route_t r;
        r = mdma_pkg::MDMA_RT_EXT;
        if (sel[`MDMA_MAP_SEL_LO_BIT]) // R4
        begin
            if (a <= `MDMA_INT_ADDR_MAX)
                r = mdma_pkg::MDMA_RT_INT; // R1
            else if (!sel[`MDMA_MAP_SEL_HI_BIT])
                r = mdma_pkg::MDMA_RT_EXT; // R2
            else if (a == `MDMA_LOCK_ADDR)
                r = mdma_pkg::MDMA_RT_LOCK; // R5
            else
                r = mdma_pkg::MDMA_RT_RSV; // R6
        end
        // Codes 00 and 10 both fall through to external
        return r; // R3 R19
    endfunction

    // ****************************************
    // Special-register file
    // ****************************************

    // Pointer registers; a register write beats a load or increment
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ptr0_lo_q <= `MDMA_RST_PTR;
            ptr0_hi_q <= `MDMA_RST_PTR;
            ptr1_lo_q <= `MDMA_RST_PTR;
            ptr1_hi_q <= `MDMA_RST_PTR;
        end
        else if (i_sfr_wr)
        begin
            if (i_sfr_addr == `MDMA_OFS_PTR0_LO) ptr0_lo_q <= i_sfr_wdata; // R14
            if (i_sfr_addr == `MDMA_OFS_PTR0_HI) ptr0_hi_q <= i_sfr_wdata; // R14
            if (i_sfr_addr == `MDMA_OFS_PTR1_LO) ptr1_lo_q <= i_sfr_wdata; // R14
            if (i_sfr_addr == `MDMA_OFS_PTR1_HI) ptr1_hi_q <= i_sfr_wdata; // R14
        end
        else if (i_ptr_load || i_ptr_inc)
        begin
            // Only the selected pointer moves
            if (ptr_sel_q) {ptr1_hi_q, ptr1_lo_q} <= i_ptr_load ? i_ptr_load_val : 16'(ptr_sel_val + 16'h0001); // R16
            else           {ptr0_hi_q, ptr0_lo_q} <= i_ptr_load ? i_ptr_load_val : 16'(ptr_sel_val + 16'h0001); // R16
        end
    end

    // Select bit keeps only the lsb of a register write; loads and increments never change it
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            ptr_sel_q <= `MDMA_RST_PTR_SEL;
        else if (i_sfr_wr && i_sfr_addr == `MDMA_OFS_PTR_SEL)
            ptr_sel_q <= i_sfr_wdata[0]; // R15
    end

    // Stretch and power registers; upper bits stored for other units
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            stretch_ctl_q <= `MDMA_RST_STRETCH; // R10
            pwr_mgmt_q    <= `MDMA_RST_PWR_MGMT; // R3
        end
        else if (i_sfr_wr)
        begin
            if (i_sfr_addr == `MDMA_OFS_STRETCH)  stretch_ctl_q <= i_sfr_wdata;
            if (i_sfr_addr == `MDMA_OFS_PWR_MGMT) pwr_mgmt_q    <= i_sfr_wdata; // R4
        end
    end

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_sfr_rdata <= 8'h00;
        else if (i_sfr_rd)
        begin
            unique case (i_sfr_addr)
                `MDMA_OFS_PTR0_LO:  o_sfr_rdata <= ptr0_lo_q;
                `MDMA_OFS_PTR0_HI:  o_sfr_rdata <= ptr0_hi_q;
                `MDMA_OFS_PTR1_LO:  o_sfr_rdata <= ptr1_lo_q;
                `MDMA_OFS_PTR1_HI:  o_sfr_rdata <= ptr1_hi_q;
                `MDMA_OFS_PTR_SEL:  o_sfr_rdata <= {7'h00, ptr_sel_q}; // R15
                `MDMA_OFS_STRETCH:  o_sfr_rdata <= stretch_ctl_q;
                `MDMA_OFS_PWR_MGMT: o_sfr_rdata <= pwr_mgmt_q;
                default:            o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    assign ptr_sel_val  = ptr_sel_q ? {ptr1_hi_q, ptr1_lo_q} : {ptr0_hi_q, ptr0_lo_q}; // R16
    assign o_ptr_active = ptr_sel_val;

    // ****************************************
    // Pin synchronisers
    // ****************************************

    // Two flops on port 0 and the lock straps before any use
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            p0_sync1_q   <= 8'h00;
            p0_sync2_q   <= 8'h00;
            lock_sync1_q <= 3'h0;
            lock_sync2_q <= 3'h0;
        end
        else
        begin
            p0_sync1_q   <= i_p0_in;
            p0_sync2_q   <= p0_sync1_q;
            lock_sync1_q <= i_lock_bits;
            lock_sync2_q <= lock_sync1_q;
        end
    end

    // ****************************************
    // Access sequencer
    // ****************************************
    assign mv_addr    = i_mv_use_ptr ? ptr_sel_val : i_mv_addr; // R16
    assign o_mv_ready = (st_q == mdma_pkg::MDMA_ST_IDLE);
    assign accept     = o_mv_ready && i_mv_req;
    assign acc_route  = route_of(pwr_mgmt_q[`MDMA_MAP_SEL_HI_BIT:`MDMA_MAP_SEL_LO_BIT], mv_addr);

    // Stretch only shapes this data path; fetch timing lives elsewhere
    assign ext_total    = 6'((3'(stretch_q) + 6'(`MDMA_EXT_BASE_MC)) * `MDMA_CLKS_PER_MC); // R9 R18 R13
    assign strobe_w     = (stretch_q == 3'h0) ? 6'(`MDMA_STROBE_S0_CLKS)
                                              : 6'({3'h0, stretch_q} * `MDMA_CLKS_PER_MC); // R11
    assign strobe_start = 6'(`MDMA_ALE_CLKS + `MDMA_SETUP_BASE) + {5'h00, stretch_q != 3'h0}; // R12
    assign last_cnt     = (st_q == mdma_pkg::MDMA_ST_EXT) ? 6'(ext_total - 6'h01)
                                                         : 6'(`MDMA_INT_MCYCLES * `MDMA_CLKS_PER_MC - 1); // R8

    // Latch the whole request so register changes mid-move do no harm
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            addr_q    <= 16'h0000;
            we_q      <= 1'h0;
            wdata_q   <= 8'h00;
            stretch_q <= 3'h0;
            lock_q    <= 1'h0;
        end
        else if (accept)
        begin
            addr_q    <= mv_addr;
            we_q      <= i_mv_we;
            wdata_q   <= i_mv_wdata;
            stretch_q <= stretch_ctl_q[`MDMA_STRETCH_MSB:0]; // R9
            lock_q    <= (acc_route == mdma_pkg::MDMA_RT_LOCK);
        end
    end

    // State and clock counter
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q  <= mdma_pkg::MDMA_ST_IDLE;
            cnt_q <= 6'h00;
        end
        else
        begin
            unique case (st_q)
                mdma_pkg::MDMA_ST_IDLE:
                begin
                    cnt_q <= 6'h00;
                    if (accept)
                    begin
                        unique case (acc_route)
                            mdma_pkg::MDMA_RT_INT:  st_q <= mdma_pkg::MDMA_ST_INT; // R1
                            mdma_pkg::MDMA_RT_EXT:  st_q <= mdma_pkg::MDMA_ST_EXT; // R2 R3
                            mdma_pkg::MDMA_RT_RSV,
                            mdma_pkg::MDMA_RT_LOCK: st_q <= mdma_pkg::MDMA_ST_RSV; // R6
                        endcase
                    end
                end
                mdma_pkg::MDMA_ST_INT,
                mdma_pkg::MDMA_ST_EXT,
                mdma_pkg::MDMA_ST_RSV:
                begin
                    if (cnt_q == last_cnt)
                    begin
                        st_q  <= mdma_pkg::MDMA_ST_IDLE;
                        cnt_q <= 6'h00;
                    end
                    else
                        cnt_q <= 6'(cnt_q + 6'h01);
                end
            endcase
        end
    end

    assign o_mv_done = (st_q != mdma_pkg::MDMA_ST_IDLE) && (cnt_q == last_cnt);

    // ****************************************
    // On-chip SRAM
    // ****************************************

    // One access at the first clock of an internal move
    assign sram_en = (st_q == mdma_pkg::MDMA_ST_INT) && (cnt_q == 6'h00);

    mdma_sram #(
        .DEPTH (SRAM_DEPTH),
        .WIDTH (8),
        .AW    (10)
    ) u_sram (
        .i_clk_sys (i_clk_sys),
        .i_en      (sram_en),
        .i_we      (we_q), // R7
        .i_addr    (addr_q[9:0]),
        .i_wdata   (wdata_q),
        .o_rdata   (sram_rdata)
    );

    // ****************************************
    // Read data return
    // ****************************************

    // Capture point for external reads sits after the synchroniser delay
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            mv_rdata_q <= 8'h00;
        else if (st_q == mdma_pkg::MDMA_ST_INT && cnt_q == 6'h01 && !we_q)
            mv_rdata_q <= sram_rdata;
        else if (st_q == mdma_pkg::MDMA_ST_RSV && cnt_q == 6'h00)
            mv_rdata_q <= (lock_q && !we_q) ? {5'h00, lock_sync2_q} : 8'h00; // R5 R20
        else if (st_q == mdma_pkg::MDMA_ST_EXT && !we_q && cnt_q == 6'(strobe_start + strobe_w + 6'h01))
            mv_rdata_q <= p0_sync2_q;
    end

    assign o_mv_rdata = mv_rdata_q;

    // ****************************************
    // External bus pins
    // ****************************************

    // Decoded from one counter; strobes change on clock edges and on reset only
    assign ale_on    = (cnt_q < 6'(`MDMA_ALE_CLKS));
    assign strobe_on = (cnt_q >= strobe_start) && (cnt_q < 6'(strobe_start + strobe_w)); // R11 R12

    assign o_bus_active = (st_q == mdma_pkg::MDMA_ST_EXT); // R17
    assign o_ale        = o_bus_active && ale_on;
    assign o_rd_n       = !(o_bus_active && strobe_on && !we_q);
    assign o_wr_n       = !(o_bus_active && strobe_on && we_q);
    assign o_p2_out     = o_bus_active ? addr_q[15:8] : 8'h00; // R17
    assign o_p0_out     = !o_bus_active ? 8'h00 : (ale_on ? addr_q[7:0] : wdata_q); // R17
    assign o_p0_oe      = o_bus_active && (ale_on || we_q); // R20

    // ****************************************
    // Checks
    // ****************************************
    logic [5:0] strobe_len_q;

    // Length of the current strobe, for the width check
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            strobe_len_q <= 6'h00;
        else if (!o_rd_n || !o_wr_n)
            strobe_len_q <= 6'(strobe_len_q + 6'h01);
        else
            strobe_len_q <= 6'h00;
    end

    property p_int_two_mc;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (accept && acc_route == mdma_pkg::MDMA_RT_INT) |-> ##8 o_mv_done;
    endproperty
    a_int_two_mc: assert property (p_int_two_mc) else $error("internal move not two machine cycles"); // R8

    property p_int_route;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (accept && pwr_mgmt_q[0] && mv_addr <= 16'h03FF) |=> (st_q == mdma_pkg::MDMA_ST_INT) && !o_bus_active;
    endproperty
    a_int_route: assert property (p_int_route) else $error("low address not served internally"); // R1

    property p_ext_high;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (accept && pwr_mgmt_q[1:0] == 2'h1 && mv_addr > 16'h03FF) |=> o_bus_active ##1 o_ale;
    endproperty
    a_ext_high: assert property (p_ext_high) else $error("high address not sent external"); // R2

    property p_disabled_ext;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (accept && !pwr_mgmt_q[0]) |=> (st_q == mdma_pkg::MDMA_ST_EXT);
    endproperty
    a_disabled_ext: assert property (p_disabled_ext) else $error("disabled map did not go external"); // R3 R19

    property p_rsv_quiet;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (accept && acc_route == mdma_pkg::MDMA_RT_RSV) |=> (!o_bus_active && o_rd_n && o_wr_n && !o_p0_oe) [*8];
    endproperty
    a_rsv_quiet: assert property (p_rsv_quiet) else $error("reserved area caused bus activity"); // R6 R20

    property p_lock_byte;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (accept && acc_route == mdma_pkg::MDMA_RT_LOCK && !i_mv_we && $stable(lock_sync2_q))
        |-> ##8 (o_mv_done && o_mv_rdata == {5'h00, $past(lock_sync2_q, 7)});
    endproperty
    a_lock_byte: assert property (p_lock_byte) else $error("lock status byte wrong"); // R5

    property p_strobe_width;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        ($rose(o_rd_n) || $rose(o_wr_n))
        |-> (strobe_len_q == ((stretch_q == 3'h0) ? 6'h02 : {1'b0, stretch_q, 2'b00}));
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width does not match stretch"); // R11

    property p_ext_length;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (o_bus_active && o_mv_done) |-> (cnt_q == 6'(({3'h0, stretch_q} + 6'h02) * 6'h04 - 6'h01));
    endproperty
    a_ext_length: assert property (p_ext_length) else $error("external move length wrong"); // R9 R18

    property p_sel_read;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_sfr_rd && i_sfr_addr == 8'h86) |=> (o_sfr_rdata[7:1] == 7'h00 && o_sfr_rdata[0] == $past(ptr_sel_q));
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select register upper bits not zero"); // R15

endmodule

`default_nettype wire

// File: logic/mdma_consts.svh
// Constants for the data-move access unit: register offsets, fields, resets, timing.
// Assumes inclusion by bare name from logic files compiled after it.
`ifndef MDMA_CONSTS_SVH
`define MDMA_CONSTS_SVH

// ****************************************
// Special-register offsets
// ****************************************
`define MDMA_OFS_PTR0_LO     8'h82
`define MDMA_OFS_PTR0_HI     8'h83
`define MDMA_OFS_PTR1_LO     8'h84
`define MDMA_OFS_PTR1_HI     8'h85
`define MDMA_OFS_PTR_SEL     8'h86
`define MDMA_OFS_STRETCH     8'h8E
`define MDMA_OFS_PWR_MGMT    8'hC4

// ****************************************
// Fields and reset values
// ****************************************
`define MDMA_MAP_SEL_LO_BIT  0
`define MDMA_MAP_SEL_HI_BIT  1
`define MDMA_STRETCH_MSB     2
`define MDMA_RST_PTR         8'h00
`define MDMA_RST_PTR_SEL     1'h0
`define MDMA_RST_STRETCH     8'h01
`define MDMA_RST_PWR_MGMT    8'h40

// ****************************************
// Address map
// ****************************************
`define MDMA_INT_ADDR_MAX    16'h03FF
`define MDMA_LOCK_ADDR       16'hFFFC

// ****************************************
// Timing in clocks and machine cycles
// ****************************************
`define MDMA_CLKS_PER_MC     4
`define MDMA_INT_MCYCLES     2
`define MDMA_EXT_BASE_MC     2
`define MDMA_STROBE_S0_CLKS  2
`define MDMA_ALE_CLKS        2
`define MDMA_SETUP_BASE      1

`endif

// File: logic/mdma_pkg.sv
// Types shared by the data-move access unit.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mdma_pkg;

    // Access sequencer states
    typedef enum logic [1:0] {
        MDMA_ST_IDLE,
        MDMA_ST_INT,
        MDMA_ST_EXT,
        MDMA_ST_RSV
    } mdma_state_t;

    // Where one data move goes
    typedef enum logic [1:0] {
        MDMA_RT_INT,
        MDMA_RT_EXT,
        MDMA_RT_RSV,
        MDMA_RT_LOCK
    } mdma_route_t;

endpackage

`default_nettype wire

// File: logic/mdma_sram.sv
// On-chip data SRAM: synchronous write, registered read.
// Assumes a single clock; contents are never reset.
`default_nettype none

module mdma_sram #(
    parameter int DEPTH = 1024,
    parameter int WIDTH = 8,
    parameter int AW    = 10
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_en,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_addr,
    input  wire logic [WIDTH-1:0] i_wdata,
    output logic      [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset on the array so contents survive map changes
    always_ff @(posedge i_clk_sys)
    begin
        if (i_en && i_we)
        begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Read port, one clock latency
    always_ff @(posedge i_clk_sys)
    begin
        if (i_en)
        begin
            o_rdata <= mem[i_addr];
        end
    end

endmodule

`default_nettype wire

// File: testbench/mdma_ext_mem.sv
// External data RAM on the multiplexed port 0/2 bus.
// Assumes the unit drives ALE, both strobes and the port 0 enable.
`default_nettype none

module mdma_ext_mem (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_p0_out,
    input  wire logic       i_p0_oe,
    input  wire logic [7:0] i_p2_out,
    input  wire logic       i_ale,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    output logic      [7:0] o_p0_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] lo_q;
    logic [7:0] last_q = 8'hA5;
    // Known fill so reads are predictable: low byte xor high byte
    initial for (int a = 0; a < 65536; a++) mem[a] = 8'(a ^ (a >> 8));
    // Pin level; a released bus flips every clock so stale data never matches
    assign o_p0_pin = i_p0_oe ? i_p0_out : (!i_rd_n ? mem[{i_p2_out, lo_q}] : ~last_q);
    // Latch the low address, store writes while the strobe is low
    always @(posedge i_clk_sys)
    begin
        last_q <= o_p0_pin;
        if (i_ale) lo_q <= i_p0_out;
        if (!i_wr_n) mem[{i_p2_out, lo_q}] <= i_p0_out;
    end
endmodule

`default_nettype wire

// File: testbench/external_move_instruction_data_memory_access_bench.sv
// Self-checking bench for the data-move unit with an external RAM model.
// Assumes design files and the RAM model are compiled first.
`default_nettype none

module external_move_instruction_data_memory_access_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [1:0] map; logic [2:0] s; logic w; logic [15:0] a; logic [7:0] d;
                           logic ext;} mdma_row_t;
    logic        clk, rstn, sfr_wr, sfr_rd, inc, load, req, we, use_ptr, ready, done, p0_oe, bus, ale, rd_n, wr_n;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, wdata, rdata, p0_in, p0_out, p2;
    logic [15:0] load_val, ptr, addr;
    logic [2:0]  lock;
    int          bad_count = 0;
    int          n_tests = 0;
    logic [7:0]  offs [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8E, 8'hC4, 8'h90};
    logic [7:0]  rsts [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'h00};
    mdma_row_t   rows [13] = '{
        '{2'h1, 3'h0, 1'b1, 16'h0010, 8'hAA, 1'b0},
        '{2'h1, 3'h0, 1'b0, 16'h0010, 8'hAA, 1'b0},
        '{2'h1, 3'h0, 1'b1, 16'h0400, 8'h5C, 1'b1},
        '{2'h1, 3'h0, 1'b0, 16'h0400, 8'h5C, 1'b1},
        '{2'h0, 3'h7, 1'b0, 16'h0010, 8'h10, 1'b1},
        '{2'h2, 3'h2, 1'b0, 16'h0311, 8'h12, 1'b1},
        '{2'h3, 3'h3, 1'b0, 16'h0010, 8'hAA, 1'b0},
        '{2'h3, 3'h3, 1'b0, 16'hFFFC, 8'h05, 1'b0},
        '{2'h3, 3'h3, 1'b1, 16'h8000, 8'h77, 1'b0},
        '{2'h3, 3'h3, 1'b0, 16'h8000, 8'h00, 1'b0},
        '{2'h0, 3'h1, 1'b0, 16'h8000, 8'h80, 1'b1},
        '{2'h1, 3'h5, 1'b1, 16'hFFFF, 8'h3C, 1'b1},
        '{2'h1, 3'h5, 1'b0, 16'hFFFF, 8'h3C, 1'b1}};

    // ****************************************
    // Design and far-side RAM
    // ****************************************
    mdma_top mdma_top_i (.i_clk_sys(clk), .i_rstn(rstn), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
        .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_ptr_inc(inc),
        .i_ptr_load(load), .i_ptr_load_val(load_val), .o_ptr_active(ptr), .i_mv_req(req), .i_mv_we(we),
        .i_mv_use_ptr(use_ptr), .i_mv_addr(addr), .i_mv_wdata(wdata), .o_mv_ready(ready), .o_mv_done(done),
        .o_mv_rdata(rdata), .i_lock_bits(lock), .i_p0_in(p0_in), .o_p0_out(p0_out), .o_p0_oe(p0_oe),
        .o_p2_out(p2), .o_bus_active(bus), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n));
    mdma_ext_mem mdma_ext_mem_i (.i_clk_sys(clk), .i_p0_out(p0_out), .i_p0_oe(p0_oe), .i_p2_out(p2),
        .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_p0_pin(p0_in));

    // ****************************************
    // Compare, report and bus tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Register write: one-cycle strobe, launched just after an edge
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
    endtask

    // Register read: data stands one cycle after the strobe
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1;
        sfr_rd = 1'b0;
        check("sfr_rdata", {24'h0, exp}, {24'h0, sfr_rdata});
    endtask

    // One data move; with the pointer in use the explicit address is spoiled
    task automatic mv(input logic w, input logic up, input logic [15:0] a, input logic [7:0] d,
                      input int s, input logic ext);
        int n, nale, nstb, st, errs;
        n = 1;
        nale = 0;
        nstb = 0;
        st = -1;
        errs = 0;
        @(posedge clk);
        #1;
        req = 1'b1;
        we = w;
        use_ptr = up;
        addr = up ? ~a : a;
        wdata = d;
        @(posedge clk);
        #1;
        req = 1'b0;
        for (int k = 0; k < 100; k++)
        begin
            @(negedge clk);
            nale += int'(ale);
            if (!rd_n || !wr_n)
            begin
                nstb++;
                if (st < 0) st = n - 1;
            end
            if ((bus && p2 !== a[15:8]) || (w && !rd_n) || (!w && !wr_n)) errs++;
            if (done === 1'b1) break;
            n++;
        end
        if (done !== 1'b1)
        begin
            check("move_timeout", 1, 0);
            tally_and_finish();
        end
        check("cycles", ext ? 4 * (s + 2) : 8, n);
        check("ale_clocks", ext ? 2 : 0, nale);
        check("strobe_clocks", ext ? (s == 0 ? 2 : 4 * s) : 0, nstb);
        check("strobe_start", ext ? (s == 0 ? 3 : 4) : -1, st);
        check("bus_errors", 0, errs);
        if (!w) check("mv_rdata", {24'h0, d}, {24'h0, rdata});
    endtask

    task automatic cfg(input logic [1:0] map, input logic [2:0] s);
        wreg(8'hC4, {6'h10, map});
        wreg(8'h8E, {5'h00, s});
    endtask

    task automatic pulse_ptr(input logic ld, input logic [15:0] v);
        @(posedge clk);
        #1;
        load = ld;
        inc = !ld;
        load_val = v;
        @(posedge clk);
        #1;
        load = 1'b0;
        inc = 1'b0;
    endtask

    // ****************************************
    // Clock and main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        {rstn, sfr_wr, sfr_rd, inc, load, req, we, use_ptr} = 8'h00;
        {sfr_addr, sfr_wdata, wdata} = 24'h000000;
        {load_val, addr} = 32'h00000000;
        lock = 3'b101;
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        check("idle_ready", 1, {31'h0, ready});
        foreach (offs[i]) rreg(offs[i], rsts[i]);
        mv(1'b0, 1'b0, 16'h0123, 8'h22, 1, 1'b1);
        foreach (rows[i])
        begin
            cfg(rows[i].map, rows[i].s);
            mv(rows[i].w, 1'b0, rows[i].a, rows[i].d, rows[i].s, rows[i].ext);
        end
        // Pointers: selection, increment carry, load, pointer-addressed move
        wreg(8'h82, 8'h10);
        wreg(8'h83, 8'h00);
        wreg(8'h84, 8'hFF);
        wreg(8'h85, 8'h00);
        check("ptr_active", 16'h0010, {16'h0, ptr});
        wreg(8'h86, 8'hFF);
        rreg(8'h86, 8'h01);
        check("ptr_active", 16'h00FF, {16'h0, ptr});
        pulse_ptr(1'b0, 16'h0000);
        rreg(8'h84, 8'h00);
        rreg(8'h85, 8'h01);
        rreg(8'h83, 8'h00);
        pulse_ptr(1'b1, 16'h0400);
        cfg(2'h1, 3'h2);
        mv(1'b0, 1'b1, 16'h0400, 8'h5C, 2, 1'b1);
        wreg(8'h86, 8'h00);
        mv(1'b0, 1'b1, 16'h0010, 8'hAA, 2, 1'b0);
        // Other lock pattern; straps settle through the synchroniser before the read
        cfg(2'h3, 3'h4);
        lock = 3'b010;
        mv(1'b0, 1'b0, 16'hFFFC, 8'h02, 4, 1'b0);
        // Reset in mid-strobe: bus must drop at once, stretch and power registers return to reset values
        cfg(2'h0, 3'h4);
        req = 1'b1;
        addr = 16'h4000;
        repeat (6) @(posedge clk);
        #1;
        req = 1'b0;
        check("bus_before_reset", 2'h2, {30'h0, bus, rd_n});
        rstn = 1'b0;
        #1;
        check("bus_in_reset", 3'h3, {29'h0, bus, rd_n, ready});
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        rreg(8'h8E, 8'h01);
        rreg(8'hC4, 8'h40);
        tally_and_finish();
    end
endmodule

`default_nettype wire
